// file: rtl/mdr_cal_mem.sv
// Small register-file memory for the hidden calibrated words of both banks.
// Assumes one write and one read per cycle; read data appear one cycle later.
`timescale 1ns/100ps
`default_nettype none
module mdr_cal_mem #(
	parameter int DEPTH = 128,
	parameter int WIDTH = 14,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_we,
	input wire logic [$clog2(DEPTH)-1:0] i_waddr,
	input wire logic [WIDTH-1:0] i_wdata,
	input wire logic [$clog2(DEPTH)-1:0] i_raddr,
	output logic [WIDTH-1:0] o_rdata
);

	logic [WIDTH-1:0] mem [DEPTH];

	// Reset values matter here, so this stays flops rather than a RAM macro
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= RESET_VAL;
			end
		end else if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= RESET_VAL;
		end else begin
			o_rdata <= mem[i_raddr];
		end
	end

endmodule // mdr_cal_mem
`default_nettype wire

// file: rtl/mdr_pkg.sv
// Constants, field layouts and carrier types for the converter register set.
// Assumes a single 40 MHz clock domain and a host on a plain register port.
// Operation
// - Forty channels form five groups of eight; group settings cover all eight.
// - Each final converter register holds a 14-bit code for the channel output.
// - Each channel has a 14-bit bank A input register, reset 0x1555.
// - Each channel has a 14-bit bank B input register, reset 0x1555.
// - Each channel has a 14-bit gain trim register, reset 0x3FFF.
// - Each channel has a 14-bit offset trim register, reset 0x2000.
// - Hidden calibrated bank A register per channel holds trimmed bank A data.
// - Hidden calibrated bank B register per channel holds trimmed bank B data.
// - Converter register loads only from calibrated A or B; never host-accessible.
// - Offset levels for group 0 and group 1, 14 bits, reset 0x1555.
// - Third offset level, reset 0x1555, shared by groups 2, 3 and 4.
// - 3-bit control resets to 0; bit 2 steers input writes to bank A/B.
// - Control bit 1 set enables thermal shutdown, clear disables it.
// - Control bit 0 set means software power-down, clear means powered up.
// - Five 8-bit bank pick registers, reset 0, choose calibrated A or B per channel.
// - Pick register bits 0..7 map to channels 0..7 of that group.
// - Input or trim writes recompute calibrated A when bank bit 0, else B.
// - With load strobe low, converter registers follow new calibrated data at once.
package mdr_pkg;

	localparam int NUM_CH = 40;
	localparam int GRP_SIZE = 8;
	localparam int NUM_GRP = 5;
	localparam int NUM_OFS = 3;
	localparam int CODE_W = 14;
	localparam int ADDR_W = 11;
	localparam int DATA_W = 16;
	localparam int CH_W = 6;
	localparam int CAL_DEPTH = 128;

	localparam logic [CODE_W-1:0] INPUT_RST = 14'h1555;
	localparam logic [CODE_W-1:0] GAIN_RST = 14'h3fff;
	localparam logic [CODE_W-1:0] OFFS_RST = 14'h2000;
	localparam logic [CODE_W-1:0] OFS_LVL_RST = 14'h1555;
	localparam logic [7:0] PICK_RST = 8'h00;
	localparam logic [CODE_W-1:0] CODE_MAX = 14'h3fff;

	// Trim arithmetic: scale by 2^14, recentre by 2^13
	localparam int CAL_SHIFT = 14;
	localparam logic [16:0] CAL_MID = 17'h0_2000;

	// Channel space: address bit 10 clear, bits 9:8 zero, kind in 7:6, channel in 5:0
	localparam int GLOBAL_BIT = 10;
	localparam int KIND_LSB = 6;
	localparam logic [1:0] KIND_INPUT = 2'h0;
	localparam logic [1:0] KIND_GAIN = 2'h1;
	localparam logic [1:0] KIND_OFFS = 2'h2;

	localparam logic [ADDR_W-1:0] ADDR_GROUP0_OFFSET_LEVEL = 11'h400;
	localparam logic [ADDR_W-1:0] ADDR_GROUP1_OFFSET_LEVEL = 11'h401;
	localparam logic [ADDR_W-1:0] ADDR_GROUP2TO4_OFFSET_LEVEL = 11'h402;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 11'h403;
	localparam logic [ADDR_W-1:0] ADDR_PICK0 = 11'h404;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 11'h409;

	localparam logic [2:0] CTRL_RST = 3'h0;

	typedef struct packed {
		logic bank_b;
		logic therm_en;
		logic pwr_down;
	} mdr_ctrl_s;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_FETCH = 1'b1
	} mdr_state_e;

endpackage

// file: rtl/mdr_top.sv
// Register set, shared trim arithmetic and converter-register loading for 40 channels.
// Assumes the host port runs on I_REF_CLK; the load strobe is an asynchronous pin.
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`default_nettype none
module mdr_top (
	input wire logic I_REF_CLK,
	input wire logic I_RST_N,
	input wire logic [mdr_pkg::ADDR_W-1:0] I_ADDR,
	input wire logic [mdr_pkg::DATA_W-1:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [mdr_pkg::DATA_W-1:0] O_RDATA,
	input wire logic I_LOAD_STROBE_N,
	output logic [mdr_pkg::NUM_CH*mdr_pkg::CODE_W-1:0] O_DAC_CODE,
	output logic [mdr_pkg::NUM_OFS*mdr_pkg::CODE_W-1:0] O_OFFSET_LEVEL,
	output logic O_THERM_SD_EN,
	output logic O_POWER_DOWN,
	output logic O_BUSY
);

	localparam int NCH = mdr_pkg::NUM_CH;
	localparam int CW = mdr_pkg::CODE_W;
	localparam int CHW = mdr_pkg::CH_W;
	localparam int MAW = $clog2(mdr_pkg::CAL_DEPTH);

	// Calibrated value with clamping to the converter range
	// Clamping trades exactness at the rails for a code that never wraps
	function automatic logic [CW-1:0] cal_fn(input logic [CW-1:0] x, input logic [CW-1:0] m,
		input logic [CW-1:0] c);
		logic [CW:0] m1;
		logic [2*CW:0] prod;
		logic signed [17:0] sum;
		m1 = {1'b0, m} + 15'h0001;
		prod = {{(CW+1){1'b0}}, x} * {{CW{1'b0}}, m1};
		sum = $signed({1'b0, prod[2*CW:mdr_pkg::CAL_SHIFT]}) + $signed({4'h0, c})
			- $signed({1'b0, mdr_pkg::CAL_MID});
		if (sum < 0) begin
			cal_fn = '0;
		end else if (sum > $signed({4'h0, mdr_pkg::CODE_MAX})) begin
			cal_fn = mdr_pkg::CODE_MAX;
		end else begin
			cal_fn = sum[CW-1:0];
		end
	endfunction

	// Lowest set bit of a channel vector
	// Fixed priority: a channel rewritten every cycle holds off the ones above it
	function automatic logic [CHW-1:0] first_fn(input logic [NCH-1:0] v);
		first_fn = '0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (v[i]) begin
				first_fn = CHW'(i);
			end
		end
	endfunction

	// Group is channel bits 5:3, position in group bits 2:0
	function automatic logic pick_fn(input logic [7:0] p [mdr_pkg::NUM_GRP],
		input logic [CHW-1:0] ch);
		pick_fn = p[ch[5:3]][ch[2:0]];
	endfunction

	logic [CW-1:0] in_a [NCH];
	logic [CW-1:0] in_b [NCH];
	logic [CW-1:0] gain [NCH];
	logic [CW-1:0] offs [NCH];
	logic [CW-1:0] dac [NCH];
	logic [CW-1:0] ofs_lvl [mdr_pkg::NUM_OFS];
	logic [7:0] pick [mdr_pkg::NUM_GRP];
	mdr_pkg::mdr_ctrl_s ctrl;
	logic [NCH-1:0] pend_a;
	logic [NCH-1:0] pend_b;
	logic [NCH-1:0] refresh;
	logic [NCH-1:0] next_pend_a;
	logic [NCH-1:0] next_pend_b;
	logic [NCH-1:0] next_refresh;
	mdr_pkg::mdr_state_e state;
	mdr_pkg::mdr_state_e next_state;
	logic [CHW-1:0] fetch_ch;
	logic ld_meta;
	logic ld_sync;
	logic ld_prev;
	logic load_low;
	logic load_fall;

	logic ch_hit;
	logic [1:0] kind;
	logic [CHW-1:0] ch;
	logic [3:0] gidx;
	logic glob_hit;
	logic calc_go;
	logic calc_bank_b;
	logic [CHW-1:0] calc_ch;
	logic [CW-1:0] calc_val;
	logic fetch_go;
	logic [CHW-1:0] fetch_next;
	logic [MAW-1:0] mem_waddr;
	logic [MAW-1:0] mem_raddr;
	logic [CW-1:0] mem_rdata;

	// Address decode
	// Kind 3, channels 40 to 63 and 0x40a upwards read zero and ignore writes
	always_comb begin
		kind = I_ADDR[mdr_pkg::KIND_LSB +: 2];
		ch = I_ADDR[CHW-1:0];
		gidx = 4'(I_ADDR - mdr_pkg::ADDR_PICK0);
		ch_hit = 1'b0;
		glob_hit = 1'b0;
		if (!I_ADDR[mdr_pkg::GLOBAL_BIT] && (I_ADDR[9:8] == 2'h0)
			&& (32'(ch) < NCH) && (kind != 2'h3)) begin
			ch_hit = 1'b1;
		end else if ((I_ADDR >= mdr_pkg::ADDR_GROUP0_OFFSET_LEVEL) && (I_ADDR <= mdr_pkg::ADDR_STATUS)) begin
			glob_hit = 1'b1;
		end
	end

	// Load strobe pin synchroniser
	// Flops reset to the idle-high level so release gives no false falling edge
	always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			ld_meta <= 1'b1;
			ld_sync <= 1'b1;
			ld_prev <= 1'b1;
		end else begin
			ld_meta <= I_LOAD_STROBE_N;
			ld_sync <= ld_meta;
			ld_prev <= ld_sync;
		end
	end

	assign load_low = !ld_sync;
	assign load_fall = ld_prev && !ld_sync;

	// Per-channel host registers
	always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			for (int i = 0; i < NCH; i++) begin
				in_a[i] <= mdr_pkg::INPUT_RST;
				in_b[i] <= mdr_pkg::INPUT_RST;
				gain[i] <= mdr_pkg::GAIN_RST;
				offs[i] <= mdr_pkg::OFFS_RST;
			end
		end else if (I_WR && ch_hit) begin
			if (kind == mdr_pkg::KIND_INPUT) begin
				if (ctrl.bank_b) begin
					in_b[ch] <= I_WDATA[CW-1:0];
				end else begin
					in_a[ch] <= I_WDATA[CW-1:0];
				end
			end else if (kind == mdr_pkg::KIND_GAIN) begin
				gain[ch] <= I_WDATA[CW-1:0];
			end else begin
				offs[ch] <= I_WDATA[CW-1:0];
			end
		end
	end

	// Global registers
	always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			for (int i = 0; i < mdr_pkg::NUM_OFS; i++) begin
				ofs_lvl[i] <= mdr_pkg::OFS_LVL_RST;
			end
			for (int g = 0; g < mdr_pkg::NUM_GRP; g++) begin
				pick[g] <= mdr_pkg::PICK_RST;
			end
			ctrl <= mdr_pkg::CTRL_RST;
		end else if (I_WR && glob_hit) begin
			if (I_ADDR == mdr_pkg::ADDR_GROUP0_OFFSET_LEVEL) begin
				ofs_lvl[0] <= I_WDATA[CW-1:0];
			end else if (I_ADDR == mdr_pkg::ADDR_GROUP1_OFFSET_LEVEL) begin
				ofs_lvl[1] <= I_WDATA[CW-1:0];
			end else if (I_ADDR == mdr_pkg::ADDR_GROUP2TO4_OFFSET_LEVEL) begin
				ofs_lvl[2] <= I_WDATA[CW-1:0];
			end else if (I_ADDR == mdr_pkg::ADDR_CTRL) begin
				ctrl <= I_WDATA[2:0];
			end else if (I_ADDR != mdr_pkg::ADDR_STATUS) begin
				pick[gidx[2:0]] <= I_WDATA[7:0];
			end
		end
	end

	// Shared multiplier scheduling: bank A work first, then bank B, then reloads
	always_comb begin
		calc_go = (state == mdr_pkg::ST_IDLE) && ((|pend_a) || (|pend_b));
		calc_bank_b = !(|pend_a);
		calc_ch = calc_bank_b ? first_fn(pend_b) : first_fn(pend_a);
		calc_val = cal_fn(calc_bank_b ? in_b[calc_ch] : in_a[calc_ch],
			gain[calc_ch], offs[calc_ch]);
		fetch_go = (state == mdr_pkg::ST_IDLE) && !calc_go && (|refresh);
		fetch_next = first_fn(refresh);
		mem_waddr = {calc_bank_b, calc_ch};
		mem_raddr = {pick_fn(pick, fetch_next), fetch_next};
		next_state = fetch_go ? mdr_pkg::ST_FETCH : mdr_pkg::ST_IDLE;
	end

	// Pending work; a write in the same cycle as completion re-arms the channel
	// A pick write with the strobe high waits for the next falling edge to reload
	always_comb begin
		next_pend_a = pend_a;
		next_pend_b = pend_b;
		next_refresh = refresh;
		if (calc_go && !calc_bank_b) begin
			next_pend_a[calc_ch] = 1'b0;
		end
		if (calc_go && calc_bank_b) begin
			next_pend_b[calc_ch] = 1'b0;
		end
		if (fetch_go) begin
			next_refresh[fetch_next] = 1'b0;
		end
		if (I_WR && ch_hit) begin
			if (!ctrl.bank_b) begin
				next_pend_a[ch] = 1'b1;
			end else begin
				next_pend_b[ch] = 1'b1;
			end
		end
		if (I_WR && glob_hit && (I_ADDR >= mdr_pkg::ADDR_PICK0)
			&& (I_ADDR != mdr_pkg::ADDR_STATUS) && load_low) begin
			for (int i = 0; i < mdr_pkg::GRP_SIZE; i++) begin
				next_refresh[{gidx[2:0], 3'(i)}] = 1'b1;
			end
		end
		if (load_fall) begin
			next_refresh = '1;
		end
		// Nothing is reloaded while the strobe is high
		if (!load_low) begin
			next_refresh = '0;
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			pend_a <= '0;
			pend_b <= '0;
			refresh <= '0;
		end else begin
			pend_a <= next_pend_a;
			pend_b <= next_pend_b;
			refresh <= next_refresh;
		end
	end

	// A reload takes two cycles because the calibrated memory has registered reads
	always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state <= mdr_pkg::ST_IDLE;
			fetch_ch <= '0;
		end else begin
			state <= next_state;
			if (fetch_go) begin
				fetch_ch <= fetch_next;
			end
		end
	end

	// Defaults give a calibrated value equal to the input default
	mdr_cal_mem #(
		.DEPTH(mdr_pkg::CAL_DEPTH),
		.WIDTH(CW),
		.RESET_VAL(mdr_pkg::INPUT_RST)
	) u_cal (
		.i_clk(I_REF_CLK),
		.i_rst_n(I_RST_N),
		.i_we(calc_go),
		.i_waddr(mem_waddr),
		.i_wdata(calc_val),
		.i_raddr(mem_raddr),
		.o_rdata(mem_rdata)
	);

	// Converter registers: direct path on a fresh result, fetch path on reloads
	always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			for (int i = 0; i < NCH; i++) begin
				dac[i] <= mdr_pkg::INPUT_RST;
			end
		// A reload already under way is dropped if the strobe has risen meanwhile
		end else if ((state == mdr_pkg::ST_FETCH) && load_low) begin
			dac[fetch_ch] <= mem_rdata;
		end else if (calc_go && load_low && (pick_fn(pick, calc_ch) == calc_bank_b)) begin
			dac[calc_ch] <= calc_val;
		end
	end

	// Host read data stand in the cycle after the strobe only
	always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_RDATA <= '0;
		end else begin
			O_RDATA <= '0;
			if (I_RD && ch_hit) begin
				if (kind == mdr_pkg::KIND_INPUT) begin
					O_RDATA <= {2'h0, ctrl.bank_b ? in_b[ch] : in_a[ch]};
				end else if (kind == mdr_pkg::KIND_GAIN) begin
					O_RDATA <= {2'h0, gain[ch]};
				end else begin
					O_RDATA <= {2'h0, offs[ch]};
				end
			end else if (I_RD && glob_hit) begin
				if (I_ADDR == mdr_pkg::ADDR_GROUP0_OFFSET_LEVEL) begin
					O_RDATA <= {2'h0, ofs_lvl[0]};
				end else if (I_ADDR == mdr_pkg::ADDR_GROUP1_OFFSET_LEVEL) begin
					O_RDATA <= {2'h0, ofs_lvl[1]};
				end else if (I_ADDR == mdr_pkg::ADDR_GROUP2TO4_OFFSET_LEVEL) begin
					O_RDATA <= {2'h0, ofs_lvl[2]};
				end else if (I_ADDR == mdr_pkg::ADDR_CTRL) begin
					O_RDATA <= {13'h0000, ctrl};
				end else if (I_ADDR == mdr_pkg::ADDR_STATUS) begin
					O_RDATA <= {14'h0000, load_low, O_BUSY};
				end else begin
					O_RDATA <= {8'h00, pick[gidx[2:0]]};
				end
			end
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_BUSY <= 1'b0;
		// Busy looks one cycle ahead so that it rises with the write that starts work
		end else begin
			O_BUSY <= (|next_pend_a) || (|next_pend_b) || (|next_refresh)
				|| (next_state == mdr_pkg::ST_FETCH);
		end
	end

	// Flattened views of flops, no logic in between
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			O_DAC_CODE[i*CW +: CW] = dac[i];
		end
		for (int i = 0; i < mdr_pkg::NUM_OFS; i++) begin
			O_OFFSET_LEVEL[i*CW +: CW] = ofs_lvl[i];
		end
	end

	assign O_THERM_SD_EN = ctrl.therm_en;
	assign O_POWER_DOWN = ctrl.pwr_down;

endmodule // mdr_top
`default_nettype wire

// file: tb/mdr_host_model.sv
// Host side of the register port: one-cycle write and read strobes.
// Assumes the block answers a read in the cycle after the strobe.
`timescale 1ns/100ps
`default_nettype none
module mdr_host_model (
	input wire logic i_clk,
	input wire logic [mdr_pkg::DATA_W-1:0] i_rdata,
	output logic [mdr_pkg::ADDR_W-1:0] o_addr,
	output logic [mdr_pkg::DATA_W-1:0] o_wdata,
	output logic o_wr,
	output logic o_rd
);
	initial begin
		o_addr = '0;
		o_wdata = '0;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	task automatic wr_reg(input logic [10:0] a, input logic [15:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
		// Stale data would hide a late sample of the write bus
		o_wdata <= ~d;
	endtask
	task automatic rd_reg(input logic [10:0] a, output logic [15:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		#1 d = i_rdata;
	endtask
endmodule // mdr_host_model
`default_nettype wire

// file: tb/mdr_top_checker.sv
// Concurrent checks on the ports of the converter register set.
// Assumes it is bound to mdr_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module mdr_top_checker (
	input wire logic I_REF_CLK,
	input wire logic I_RST_N,
	input wire logic [mdr_pkg::ADDR_W-1:0] I_ADDR,
	input wire logic [mdr_pkg::DATA_W-1:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	input wire logic [mdr_pkg::DATA_W-1:0] O_RDATA,
	input wire logic I_LOAD_STROBE_N,
	input wire logic [mdr_pkg::NUM_CH*mdr_pkg::CODE_W-1:0] O_DAC_CODE,
	input wire logic [mdr_pkg::NUM_OFS*mdr_pkg::CODE_W-1:0] O_OFFSET_LEVEL,
	input wire logic O_THERM_SD_EN,
	input wire logic O_POWER_DOWN,
	input wire logic O_BUSY
);
	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RST_N);
	chk_ctrl_write: assert property ($past(I_WR) && $past(I_ADDR) == mdr_pkg::ADDR_CTRL
		|-> O_THERM_SD_EN == $past(I_WDATA[1]) && O_POWER_DOWN == $past(I_WDATA[0]))
		else $error("control outputs differ from written value");
	chk_ctrl_hold: assert property ($changed({O_THERM_SD_EN, O_POWER_DOWN})
		|-> $past(I_WR) && $past(I_ADDR) == mdr_pkg::ADDR_CTRL)
		else $error("control outputs changed without a control write");
	chk_ctrl_read: assert property ($past(I_RD) && $past(I_ADDR) == mdr_pkg::ADDR_CTRL
		|-> O_RDATA[15:3] == 13'h0000 && O_RDATA[1:0] == {O_THERM_SD_EN, O_POWER_DOWN})
		else $error("control readback wrong");
	chk_group0_offset_level_write: assert property ($past(I_WR) && $past(I_ADDR) == mdr_pkg::ADDR_GROUP0_OFFSET_LEVEL
		|-> O_OFFSET_LEVEL[13:0] == $past(I_WDATA[13:0]))
		else $error("group 0 offset level not loaded");
	chk_group2to4_offset_level_write: assert property ($past(I_WR) && $past(I_ADDR) == mdr_pkg::ADDR_GROUP2TO4_OFFSET_LEVEL
		|-> O_OFFSET_LEVEL[41:28] == $past(I_WDATA[13:0]))
		else $error("shared offset level not loaded");
	chk_group1_offset_level_read: assert property ($past(I_RD) && $past(I_ADDR) == mdr_pkg::ADDR_GROUP1_OFFSET_LEVEL
		|-> O_RDATA == {2'b00, O_OFFSET_LEVEL[27:14]})
		else $error("group 1 offset readback wrong");
	chk_code_frozen: assert property (I_LOAD_STROBE_N [*5] |=> $stable(O_DAC_CODE))
		else $error("converter code changed with load strobe high");
	chk_busy_on_write: assert property (I_WR && I_ADDR[10:8] == 3'h0 && I_ADDR[7:6] != 2'h3
		&& I_ADDR[5:0] < 6'h28 |=> O_BUSY)
		else $error("channel write did not start a recompute");
	chk_busy_ends: assert property ($rose(O_BUSY) |-> ##[1:300] !O_BUSY)
		else $error("recompute did not finish in time");
	chk_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == 16'h0000)
		else $error("read data not zero outside a read answer");
endmodule // mdr_top_checker
bind mdr_top mdr_top_checker u_chk (.I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR),
	.I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
	.I_LOAD_STROBE_N(I_LOAD_STROBE_N), .O_DAC_CODE(O_DAC_CODE), .O_OFFSET_LEVEL(O_OFFSET_LEVEL),
	.O_THERM_SD_EN(O_THERM_SD_EN), .O_POWER_DOWN(O_POWER_DOWN), .O_BUSY(O_BUSY));
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the converter register set.
// Assumes the host model drives the register port and the bench drives the load strobe.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic clk, rst_n, strobe_n, wr, rd, therm, pdn, busy;
	logic [10:0] addr;
	logic [15:0] wdata, rdata;
	logic [mdr_pkg::NUM_CH*mdr_pkg::CODE_W-1:0] dac;
	logic [mdr_pkg::NUM_OFS*mdr_pkg::CODE_W-1:0] ofs;
	int n_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	mdr_top uut (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
		.I_RD(rd), .O_RDATA(rdata), .I_LOAD_STROBE_N(strobe_n), .O_DAC_CODE(dac),
		.O_OFFSET_LEVEL(ofs), .O_THERM_SD_EN(therm), .O_POWER_DOWN(pdn), .O_BUSY(busy));
	mdr_host_model host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
		.o_wr(wr), .o_rd(rd));
	function automatic logic [10:0] ca(input logic [1:0] k, input int ch);
		return {3'b000, k, 6'(ch)};
	endfunction
	// Expected trimmed code, clamped to the converter range
	function automatic logic [15:0] cal(input int x, input int m, input int c);
		int v;
		v = ((x * (m + 1)) >>> 14) + c - 8192;
		if (v < 0) v = 0;
		if (v > 16383) v = 16383;
		return 16'(v);
	endfunction
	task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", name, e, g);
		end
	endtask
	task automatic rchk(input string name, input logic [10:0] a, input logic [15:0] e);
		logic [15:0] d;
		host.rd_reg(a, d);
		chk(name, e, d);
	endtask
	task automatic cchk(input int ch, input logic [15:0] e);
		chk("dac code", e, {2'b00, dac[14*ch +: 14]});
	endtask
	task automatic settle();
		repeat (4) @(posedge clk);
		for (int i = 0; i < 300 && busy !== 1'b0; i++) @(posedge clk);
		#1 chk("busy", 16'h0000, {15'h0000, busy});
	endtask
	task automatic t_reset();
		for (int g = 0; g < 5; g++) rchk("pick", mdr_pkg::ADDR_PICK0 + 11'(g), 16'h0000);
		rchk("ctrl", mdr_pkg::ADDR_CTRL, 16'h0000);
		for (int k = 0; k < 3; k++) rchk("ofs", mdr_pkg::ADDR_GROUP0_OFFSET_LEVEL + 11'(k), 16'h1555);
		chk("ofs pins", 16'h1555, {2'b00, ofs[41:28]});
		for (int ch = 0; ch < 40; ch += 39) begin
			rchk("input a", ca(0, ch), 16'h1555);
			rchk("gain", ca(1, ch), 16'h3fff);
			rchk("offs", ca(2, ch), 16'h2000);
		end
		host.wr_reg(mdr_pkg::ADDR_CTRL, 16'h0004);
		rchk("input b", ca(0, 39), 16'h1555);
		host.wr_reg(mdr_pkg::ADDR_CTRL, 16'h0000);
		#1;
		for (int ch = 0; ch < 40; ch++) cchk(ch, 16'h1555);
	endtask
	task automatic t_calib();
		host.wr_reg(ca(0, 5), 16'h1000);
		settle();
		cchk(5, cal(4096, 16383, 8192));
		host.wr_reg(ca(1, 5), 16'h1fff);
		settle();
		cchk(5, cal(4096, 8191, 8192));
		host.wr_reg(ca(2, 5), 16'h2100);
		host.wr_reg(ca(2, 6), 16'h0000);
		host.wr_reg(ca(0, 7), 16'h3fff);
		host.wr_reg(ca(2, 7), 16'h3fff);
		settle();
		cchk(5, cal(4096, 8191, 8448));
		cchk(6, cal(5461, 16383, 0));
		cchk(7, cal(16383, 16383, 16383));
		rchk("gain", ca(1, 5), 16'h1fff);
	endtask
	task automatic t_bank_b();
		host.wr_reg(mdr_pkg::ADDR_CTRL, 16'h0004);
		host.wr_reg(ca(0, 9), 16'h0abc);
		settle();
		cchk(9, 16'h1555);
		rchk("input b", ca(0, 9), 16'h0abc);
		host.wr_reg(mdr_pkg::ADDR_PICK0 + 11'h001, 16'h0002);
		settle();
		cchk(9, 16'h0abc);
		cchk(8, 16'h1555);
		rchk("pick", mdr_pkg::ADDR_PICK0 + 11'h001, 16'h0002);
		host.wr_reg(mdr_pkg::ADDR_CTRL, 16'h0000);
		rchk("input a", ca(0, 9), 16'h1555);
		host.wr_reg(ca(1, 9), 16'h1fff);
		settle();
		cchk(9, 16'h0abc);
		host.wr_reg(mdr_pkg::ADDR_PICK0 + 11'h001, 16'h0000);
		settle();
		cchk(9, cal(5461, 8191, 8192));
	endtask
	task automatic t_strobe();
		@(posedge clk);
		strobe_n <= 1'b1;
		repeat (4) @(posedge clk);
		host.wr_reg(ca(0, 0), 16'h0100);
		repeat (20) @(posedge clk);
		#1 cchk(0, 16'h1555);
		@(posedge clk);
		strobe_n <= 1'b0;
		settle();
		cchk(0, 16'h0100);
	endtask
	task automatic t_misc();
		for (int v = 0; v < 4; v++) begin
			host.wr_reg(mdr_pkg::ADDR_CTRL, 16'(v));
			#1 chk("pins", 16'(v), {14'h0000, therm, pdn});
			rchk("ctrl", mdr_pkg::ADDR_CTRL, 16'(v));
		end
		for (int k = 0; k < 3; k++) begin
			host.wr_reg(mdr_pkg::ADDR_GROUP0_OFFSET_LEVEL + 11'(k), 16'h0123 + 16'(k));
			#1 chk("ofs pins", 16'h0123 + 16'(k), {2'b00, ofs[14*k +: 14]});
		end
		host.wr_reg(mdr_pkg::ADDR_PICK0 + 11'h004, 16'h0080);
		rchk("pick 4", mdr_pkg::ADDR_PICK0 + 11'h004, 16'h0080);
		host.wr_reg(11'h40a, 16'h1234);
		rchk("unmapped", 11'h40a, 16'h0000);
		rchk("ch 40", ca(0, 40), 16'h0000);
		rchk("kind 3", ca(3, 0), 16'h0000);
		settle();
		host.wr_reg(mdr_pkg::ADDR_STATUS, 16'hffff);
		rchk("status", mdr_pkg::ADDR_STATUS, 16'h0002);
	endtask
	// Mid-run reset: control pins, offset level 0, gain, pick 4 and converter codes 5 and 7 back to default
	task automatic t_rerst();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1 chk("pins after reset", 16'h0000, {14'h0000, therm, pdn});
		cchk(5, 16'h1555);
		settle();
		rchk("ofs after reset", mdr_pkg::ADDR_GROUP0_OFFSET_LEVEL, 16'h1555);
		rchk("gain after reset", ca(1, 5), 16'h3fff);
		rchk("pick after reset", mdr_pkg::ADDR_PICK0 + 11'h004, 16'h0000);
		cchk(7, 16'h1555);
	endtask
	task automatic summarize();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Whole run needs well under this many cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_errors++;
			summarize();
		end
	end
	initial begin
		rst_n = 1'b0;
		strobe_n = 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_calib();
		t_bank_b();
		t_strobe();
		t_misc();
		t_rerst();
		summarize();
	end
endmodule // tb_top
`default_nettype wire
